// file: design/unaligned_word_load_merge.sv
// Overview of operation
// - Left part: bytes by offset and endianness
// - Back-to-back same destination merges forwarded data
// - Left part reports translation, bus, address errors
// - Right part decoded from its major opcode
// - Address is base plus signed offset
// - Right part fills low end of word
// - Right part, four bytes: sign-extend upper half
// - Right part partial: one fixed upper policy
// - Both parts together give sign-extended word
// - Right part: bytes by offset and endianness
// - Merge target is the low word
// - Upper half is never zero-filled
// - Left part always sign-extends upper half
// - Left part fills high end of word
// - Left part decoded from its major opcode
`timescale 1ns/1ps
`default_nettype none

module unaligned_word_load_merge
(
	input  wire logic        mclk,
	input  wire logic        resetn,
	input  wire logic        issue_valid,
	output logic             issue_ready,
	input  wire logic [31:0] instr_word,
	input  wire logic [63:0] base_value,
	input  wire logic [63:0] dest_old_value,
	input  wire logic        cpu_big_endian_setting,
	input  wire logic        reverse_endian_setting,
	input  wire logic        memory_big_endian_setting,
	output logic             mem_req_valid,
	output logic [63:0]      mem_req_addr,
	input  wire logic        mem_rsp_valid,
	input  wire logic [63:0] mem_rsp_data,
	input  wire logic        mem_rsp_tlb_refill,
	input  wire logic        mem_rsp_tlb_invalid,
	input  wire logic        mem_rsp_bus_error,
	input  wire logic        mem_rsp_address_error,
	output logic             wb_valid,
	output logic [4:0]       wb_dest,
	output logic [63:0]      wb_data,
	output logic             exc_valid,
	output logic [1:0]       exc_code,
	output logic [63:0]      effective_byte_address
);
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_MEM
	} state_type;

	function automatic unaligned_load_pkg::load_kind_type decode_kind
	(
		input logic [31:0] word
	);
		logic [5:0] op;
		op = word[unaligned_load_pkg::OPCODE_MSB:unaligned_load_pkg::OPCODE_LSB];
		if (op == unaligned_load_pkg::OPCODE_LEFT)
			return unaligned_load_pkg::KIND_LEFT;
		else if (op == unaligned_load_pkg::OPCODE_RIGHT)
			return unaligned_load_pkg::KIND_RIGHT;
		else
			return unaligned_load_pkg::KIND_NONE;
	endfunction

	state_type                      state_ff, nxt_state;
	unaligned_load_pkg::load_kind_type kind_ff, nxt_kind;
	logic [63:0]                    ea_ff, nxt_ea;
	logic [63:0]                    old_ff, nxt_old;
	logic [4:0]                     dest_ff, nxt_dest;
	logic [1:0]                     sel_ff, nxt_sel;
	logic                           word_sel_ff, nxt_word_sel;
	logic [63:0]                    paddr_ff, nxt_paddr;
	logic                           wb_valid_ff, nxt_wb_valid;
	logic [63:0]                    wb_data_ff, nxt_wb_data;
	logic [3:0]                     lane_en_ff, nxt_lane_en;
	logic                           exc_valid_ff, nxt_exc_valid;
	logic [1:0]                     exc_code_ff, nxt_exc_code;
	logic                           last_valid_ff, nxt_last_valid;
	logic [4:0]                     last_dest_ff, nxt_last_dest;
	logic [63:0]                    last_data_ff, nxt_last_data;

	logic                           accept;
	logic                           forward_hit;
	logic                           rsp_error;
	logic [4:0]                     issue_dest;
	logic [63:0]                    issue_ea;
	logic [63:0]                    offset_ext;
	logic [2:0]                     phys_low;

	merge_if mg ();

	byte_merge_unit u_merge
	(
		.m (mg.unit)
	);

	// ****************************************************************
	// Issue side
	// ****************************************************************
	assign issue_ready = (state_ff == ST_IDLE);
	// Other opcodes are taken and dropped without a response
	assign accept      = issue_valid && issue_ready &&
		(decode_kind(instr_word) != unaligned_load_pkg::KIND_NONE);
	assign issue_dest  = instr_word[unaligned_load_pkg::DEST_MSB:
		unaligned_load_pkg::DEST_LSB];
	assign offset_ext  = {{48{instr_word[15]}}, instr_word[15:0]};
	// No alignment check: low bits are the byte position
	assign issue_ea    = base_value + offset_ext;
	// Result not yet in the register file when loads follow back to back
	assign forward_hit = last_valid_ff && (last_dest_ff == issue_dest);

	always_comb
	begin
		phys_low = issue_ea[2:0] ^ {3{reverse_endian_setting}};
		if (!memory_big_endian_setting)
			phys_low = 3'h0;
	end

	assign rsp_error = mem_rsp_tlb_refill || mem_rsp_tlb_invalid ||
		mem_rsp_bus_error || mem_rsp_address_error;

	// ****************************************************************
	// Merge datapath hookup
	// ****************************************************************
	assign mg.is_left   = (kind_ff == unaligned_load_pkg::KIND_LEFT);
	assign mg.byte_sel  = sel_ff;
	assign mg.old_value = old_ff;
	assign mg.mem_word  = word_sel_ff ? mem_rsp_data[63:32] :
		mem_rsp_data[31:0];

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	always_comb
	begin
		nxt_state      = state_ff;
		nxt_kind       = kind_ff;
		nxt_ea         = ea_ff;
		nxt_old        = old_ff;
		nxt_dest       = dest_ff;
		nxt_sel        = sel_ff;
		nxt_word_sel   = word_sel_ff;
		nxt_paddr      = paddr_ff;
		nxt_wb_valid   = 1'b0;
		nxt_wb_data    = wb_data_ff;
		nxt_lane_en    = lane_en_ff;
		nxt_exc_valid  = 1'b0;
		nxt_exc_code   = exc_code_ff;
		nxt_last_valid = last_valid_ff;
		nxt_last_dest  = last_dest_ff;
		nxt_last_data  = last_data_ff;
		case (state_ff)
			ST_IDLE:
			begin
				if (accept)
				begin
					nxt_state    = ST_MEM;
					nxt_kind     = decode_kind(instr_word);
					nxt_ea       = issue_ea;
					nxt_dest     = issue_dest;
					nxt_old      = forward_hit ? last_data_ff :
						dest_old_value;
					nxt_sel      = issue_ea[1:0] ^
						{2{cpu_big_endian_setting}};
					nxt_word_sel = issue_ea[2] ^ cpu_big_endian_setting;
					nxt_paddr    = {issue_ea[63:3], phys_low};
				end
			end
			ST_MEM:
			begin
				if (mem_rsp_valid)
				begin
					nxt_state = ST_IDLE;
					if (rsp_error)
					begin
						nxt_exc_valid  = 1'b1;
						nxt_last_valid = 1'b0;
						if (mem_rsp_address_error)
							nxt_exc_code = unaligned_load_pkg::EXC_ADDRESS_ERROR;
						else if (mem_rsp_tlb_refill)
							nxt_exc_code = unaligned_load_pkg::EXC_TLB_REFILL;
						else if (mem_rsp_tlb_invalid)
							nxt_exc_code = unaligned_load_pkg::EXC_TLB_INVALID;
						else
							nxt_exc_code = unaligned_load_pkg::EXC_BUS_ERROR;
					end
					else
					begin
						nxt_wb_valid   = 1'b1;
						nxt_wb_data    = mg.result;
						nxt_lane_en    = mg.lane_en;
						nxt_last_valid = 1'b1;
						nxt_last_dest  = dest_ff;
						nxt_last_data  = mg.result;
					end
				end
			end
			default:
			begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_ff      <= ST_IDLE;
			kind_ff       <= unaligned_load_pkg::KIND_NONE;
			ea_ff         <= unaligned_load_pkg::DATA_RESET;
			old_ff        <= unaligned_load_pkg::DATA_RESET;
			dest_ff       <= unaligned_load_pkg::DEST_RESET;
			sel_ff        <= 2'h0;
			word_sel_ff   <= 1'b0;
			paddr_ff      <= unaligned_load_pkg::DATA_RESET;
			wb_valid_ff   <= 1'b0;
			wb_data_ff    <= unaligned_load_pkg::DATA_RESET;
			lane_en_ff    <= 4'h0;
			exc_valid_ff  <= 1'b0;
			exc_code_ff   <= 2'h0;
			last_valid_ff <= 1'b0;
			last_dest_ff  <= unaligned_load_pkg::DEST_RESET;
			last_data_ff  <= unaligned_load_pkg::DATA_RESET;
		end
		else
		begin
			state_ff      <= nxt_state;
			kind_ff       <= nxt_kind;
			ea_ff         <= nxt_ea;
			old_ff        <= nxt_old;
			dest_ff       <= nxt_dest;
			sel_ff        <= nxt_sel;
			word_sel_ff   <= nxt_word_sel;
			paddr_ff      <= nxt_paddr;
			wb_valid_ff   <= nxt_wb_valid;
			wb_data_ff    <= nxt_wb_data;
			lane_en_ff    <= nxt_lane_en;
			exc_valid_ff  <= nxt_exc_valid;
			exc_code_ff   <= nxt_exc_code;
			last_valid_ff <= nxt_last_valid;
			last_dest_ff  <= nxt_last_dest;
			last_data_ff  <= nxt_last_data;
		end
	end

	assign mem_req_valid          = (state_ff == ST_MEM);
	assign mem_req_addr           = paddr_ff;
	assign wb_valid               = wb_valid_ff;
	assign wb_dest                = dest_ff;
	assign wb_data                = wb_data_ff;
	assign exc_valid              = exc_valid_ff;
	assign exc_code               = exc_code_ff;
	assign effective_byte_address = ea_ff;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	sequence seq_accept;
		accept;
	endsequence

	sequence seq_rsp_ok;
		mem_req_valid && mem_rsp_valid && !rsp_error;
	endsequence

	sequence seq_rsp_err;
		mem_req_valid && mem_rsp_valid && rsp_error;
	endsequence

	a_ea_from_base: assert property (seq_accept |=>
		effective_byte_address == $past(base_value + offset_ext, 1))
		else $error("effective address not base plus offset");

	a_byte_select: assert property (seq_accept |=>
		sel_ff == $past(issue_ea[1:0] ^ {2{cpu_big_endian_setting}}, 1))
		else $error("byte select not endian adjusted");

	a_req_follows: assert property (seq_accept |=> mem_req_valid)
		else $error("no memory request after issue");

	a_wb_after_ok: assert property (seq_rsp_ok |=>
		wb_valid && !exc_valid ##1 !wb_valid)
		else $error("write-back missing or longer than a pulse");

	a_exc_after_err: assert property (seq_rsp_err |=>
		exc_valid && !wb_valid)
		else $error("exception not reported after error");

	a_left_sign: assert property (
		wb_valid && kind_ff == unaligned_load_pkg::KIND_LEFT |->
		wb_data[63:32] == {32{wb_data[31]}})
		else $error("left part upper half not sign extended");

	a_right_full: assert property (
		wb_valid && kind_ff == unaligned_load_pkg::KIND_RIGHT &&
		sel_ff == 2'h0 |-> wb_data[63:32] == {32{wb_data[31]}})
		else $error("right part full word not sign extended");

	a_right_partial: assert property (
		wb_valid && kind_ff == unaligned_load_pkg::KIND_RIGHT &&
		sel_ff != 2'h0 && !unaligned_load_pkg::RIGHT_PARTIAL_SIGN_FILL |->
		wb_data[63:32] == old_ff[63:32])
		else $error("right part partial changed upper half");

	a_kept_bytes: assert property (wb_valid |->
		((wb_data[31:0] ^ old_ff[31:0]) &
		~{{8{lane_en_ff[3]}}, {8{lane_en_ff[2]}},
		{8{lane_en_ff[1]}}, {8{lane_en_ff[0]}}}) == 32'h0)
		else $error("unselected byte changed");

	a_forward_use: assert property (accept && forward_hit |=>
		old_ff == $past(last_data_ff, 1))
		else $error("preceding load data not forwarded");
endmodule

`default_nettype wire

// file: design/unaligned_load_pkg.sv
package unaligned_load_pkg;

	// ****************************************************************
	// Instruction word fields
	// ****************************************************************
	localparam int          OPCODE_MSB   = 31;
	localparam int          OPCODE_LSB   = 26;
	localparam int          BASE_MSB     = 25;
	localparam int          BASE_LSB     = 21;
	localparam int          DEST_MSB     = 20;
	localparam int          DEST_LSB     = 16;
	localparam int          OFFSET_MSB   = 15;
	localparam int          OFFSET_LSB   = 0;
	localparam logic [5:0]  OPCODE_LEFT  = 6'h22;
	localparam logic [5:0]  OPCODE_RIGHT = 6'h26;

	// ****************************************************************
	// Widths, reset values and policy
	// ****************************************************************
	localparam int          REG_WIDTH    = 64;
	localparam int          WORD_WIDTH   = 32;
	localparam int          OFFSET_WIDTH = 16;
	localparam int          LANE_COUNT   = 4;
	localparam logic [63:0] DATA_RESET   = 64'h0;
	localparam logic [4:0]  DEST_RESET   = 5'h0;
	// Partial right-part load: 0 keeps upper half, 1 copies old bit 31
	localparam logic        RIGHT_PARTIAL_SIGN_FILL = 1'b0;

	// ****************************************************************
	// Exception codes, in falling priority
	// ****************************************************************
	localparam logic [1:0]  EXC_ADDRESS_ERROR = 2'h0;
	localparam logic [1:0]  EXC_TLB_REFILL    = 2'h1;
	localparam logic [1:0]  EXC_TLB_INVALID   = 2'h2;
	localparam logic [1:0]  EXC_BUS_ERROR     = 2'h3;

	typedef enum logic [1:0] {
		KIND_NONE,
		KIND_LEFT,
		KIND_RIGHT
	} load_kind_type;

endpackage

// file: design/merge_if.sv
`timescale 1ns/1ps
`default_nettype none

interface merge_if;
	logic        is_left;
	logic [1:0]  byte_sel;
	logic [63:0] old_value;
	logic [31:0] mem_word;
	logic [63:0] result;
	logic [3:0]  lane_en;

	modport unit
	(
		input  is_left,
		input  byte_sel,
		input  old_value,
		input  mem_word,
		output result,
		output lane_en
	);

	modport user
	(
		output is_left,
		output byte_sel,
		output old_value,
		output mem_word,
		input  result,
		input  lane_en
	);
endinterface

`default_nettype wire

// file: design/byte_merge_unit.sv
`timescale 1ns/1ps
`default_nettype none

module byte_merge_unit
(
	merge_if.unit m
);
	logic [31:0] shifted;
	logic [31:0] low_word;
	logic        full_word;

	// ****************************************************************
	// Align fetched bytes to their destination lanes
	// ****************************************************************
	always_comb
	begin
		if (m.is_left)
			shifted = m.mem_word << (5'(3 - m.byte_sel) * 8);
		else
			shifted = m.mem_word >> (5'(m.byte_sel) * 8);
	end

	genvar i;
	generate
		for (i = 0; i < 4; i++)
		begin : g_lane
			// Left fills from the top lane down, right from lane 0 up
			assign m.lane_en[i] = m.is_left ?
				(3'(i) >= 3'(3 - m.byte_sel)) :
				(3'(i) <= 3'(3 - m.byte_sel));
			assign low_word[8*i+7:8*i] = m.lane_en[i] ?
				shifted[8*i+7:8*i] : m.old_value[8*i+7:8*i];
		end
	endgenerate

	assign full_word = m.is_left || (m.byte_sel == 2'h0);

	// ****************************************************************
	// Upper half: never zeroed
	// ****************************************************************
	always_comb
	begin
		if (full_word)
			m.result = {{32{low_word[31]}}, low_word};
		else if (unaligned_load_pkg::RIGHT_PARTIAL_SIGN_FILL)
			m.result = {{32{m.old_value[31]}}, low_word};
		else
			m.result = {m.old_value[63:32], low_word};
	end
endmodule

`default_nettype wire

// file: verification/mem_path_model.sv
`timescale 1ns/1ps
`default_nettype none

module mem_path_model
(
	input  wire logic        mclk,
	input  wire logic        resetn,
	input  wire logic        req_valid,
	input  wire logic [1:0]  delay,
	input  wire logic [3:0]  err,
	input  wire logic [63:0] dw,
	output logic             rsp_valid,
	output logic [63:0]      rsp_data,
	output logic [3:0]       rsp_err
);
	logic [1:0] cnt_ff;
	logic [1:0] nxt_cnt;
	logic       rsp_ff;
	logic       nxt_rsp;

	// One pulse per request, after a chosen wait
	always_comb
	begin
		nxt_rsp = req_valid && !rsp_ff && cnt_ff == delay;
		nxt_cnt = 2'h0;
		if (req_valid && !rsp_ff && !nxt_rsp)
			nxt_cnt = cnt_ff + 2'h1;
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			cnt_ff <= 2'h0;
			rsp_ff <= 1'b0;
		end
		else
		begin
			cnt_ff <= nxt_cnt;
			rsp_ff <= nxt_rsp;
		end
	end

	// Inverted outside the pulse so stale data is never mistaken for good
	assign rsp_valid = rsp_ff;
	assign rsp_data  = rsp_ff ? dw : ~dw;
	assign rsp_err   = rsp_ff ? err : ~err;
endmodule

`default_nettype wire

// file: verification/unaligned_word_load_merge_tb.sv
`timescale 1ns/1ps
`default_nettype none

module unaligned_word_load_merge_tb;
	localparam logic [5:0]  lft = unaligned_load_pkg::OPCODE_LEFT;
	localparam logic [5:0]  rgt = unaligned_load_pkg::OPCODE_RIGHT;
	localparam logic [63:0] dw  = 64'h0123_8567_89ab_cdef;
	localparam logic [63:0] old = 64'h5a5a_5a5a_c3c3_c3c3;

	typedef struct {
		logic [5:0]  op;
		logic [15:0] ofs;
		logic [2:0]  cfg;
		logic [63:0] exp;
	} row_type;

	row_type     rows[32];
	logic        mclk;
	logic        resetn;
	logic        issue_valid;
	logic        issue_ready;
	logic [31:0] instr_word;
	logic [63:0] base_value;
	logic [63:0] dest_old_value;
	logic [2:0]  cfg_bits;
	logic        mem_req_valid;
	logic [63:0] mem_req_addr;
	logic        mem_rsp_valid;
	logic [63:0] mem_rsp_data;
	logic [3:0]  rsp_err;
	logic [1:0]  mem_delay;
	logic [3:0]  mem_err;
	logic        wb_valid;
	logic [4:0]  wb_dest;
	logic [63:0] wb_data;
	logic        exc_valid;
	logic [1:0]  exc_code;
	logic [63:0] effective_byte_address;
	logic        got_wb;
	logic        got_exc;
	logic        got_req;
	int          fail_count;
	int          checked;

	unaligned_word_load_merge unaligned_word_load_merge_inst
	(
		.mclk,
		.resetn,
		.issue_valid,
		.issue_ready,
		.instr_word,
		.base_value,
		.dest_old_value,
		.cpu_big_endian_setting(cfg_bits[2]),
		.reverse_endian_setting(cfg_bits[1]),
		.memory_big_endian_setting(cfg_bits[0]),
		.mem_req_valid,
		.mem_req_addr,
		.mem_rsp_valid,
		.mem_rsp_data,
		.mem_rsp_tlb_refill(rsp_err[0]),
		.mem_rsp_tlb_invalid(rsp_err[1]),
		.mem_rsp_bus_error(rsp_err[2]),
		.mem_rsp_address_error(rsp_err[3]),
		.wb_valid,
		.wb_dest,
		.wb_data,
		.exc_valid,
		.exc_code,
		.effective_byte_address
	);

	mem_path_model mem_path_model_inst
	(
		.mclk,
		.resetn,
		.req_valid(mem_req_valid),
		.delay(mem_delay),
		.err(mem_err),
		.dw(dw),
		.rsp_valid(mem_rsp_valid),
		.rsp_data(mem_rsp_data),
		.rsp_err(rsp_err)
	);

	// ****************
	// Helpers
	// ****************
	task automatic check(input logic [63:0] seen, input logic [63:0] want);
		checked++;
		if (seen !== want)
		begin
			fail_count++;
			$display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask

	task automatic results;
		$display("checks=%0d mismatches=%0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	function automatic logic [63:0] merge_exp(input logic left,
		input logic [63:0] ea, input logic big);
		logic [1:0]  b;
		logic [31:0] w;
		logic [31:0] r;
		b = ea[1:0] ^ {2{big}};
		w = (ea[2] ^ big) ? dw[63:32] : dw[31:0];
		r = old[31:0];
		for (int k = 0; k < 4; k++)
		begin
			if (left && k >= 3 - b)
				r[8*k +: 8] = w[8*(k-3+b) +: 8];
			if (!left && k <= 3 - b)
				r[8*k +: 8] = w[8*(k+b) +: 8];
		end
		if (left || b == 2'h0)
			return {{32{r[31]}}, r};
		if (unaligned_load_pkg::RIGHT_PARTIAL_SIGN_FILL)
			return {{32{old[31]}}, r};
		return {old[63:32], r};
	endfunction

	task automatic run(input logic [5:0] op, input logic [63:0] base,
		input logic [15:0] ofs, input logic [4:0] dest,
		input logic [63:0] prev, input logic [2:0] cfg,
		input logic [3:0] err, input logic [63:0] exp);
		logic [63:0] ea;
		logic [1:0]  code;
		logic        ok;
		logic [63:0] pa;
		ea = base + {{48{ofs[15]}}, ofs};
		pa = {ea[63:3], cfg[0] ? ea[2:0] ^ {3{cfg[1]}} : 3'h0};
		ok = op == lft || op == rgt;
		code = err[3] ? unaligned_load_pkg::EXC_ADDRESS_ERROR :
			err[0] ? unaligned_load_pkg::EXC_TLB_REFILL :
			err[1] ? unaligned_load_pkg::EXC_TLB_INVALID :
			unaligned_load_pkg::EXC_BUS_ERROR;
		got_wb = 1'b0;
		got_exc = 1'b0;
		got_req = 1'b0;
		@(posedge mclk);
		// Only loads follow loads; all name register 3 as base, which row 3 also names as destination
		issue_valid <= 1'b1;
		instr_word <= {op, 5'h3, dest, ofs};
		base_value <= base;
		dest_old_value <= prev;
		cfg_bits <= cfg;
		mem_err <= err;
		mem_delay <= dest[1:0] ^ ofs[1:0];
		@(posedge mclk);
		issue_valid <= 1'b0;
		for (int n = 0; n < 12 && !(got_wb || got_exc); n++)
		begin
			@(posedge mclk);
			#1;
			if (mem_req_valid)
			begin
				got_req = 1'b1;
				check(mem_req_addr, pa);
				check(effective_byte_address, ea);
			end
			got_wb = wb_valid;
			got_exc = exc_valid;
		end
		check(64'(got_wb), 64'(ok && err == 4'h0));
		check(64'(got_exc), 64'(ok && err != 4'h0));
		if (got_wb)
		begin
			check(wb_data, exp);
			check(64'(wb_data[31:0]), 64'(exp[31:0]));
			check(64'(wb_data[31:24]), 64'(exp[31:24]));
			check(64'(wb_data[63:32]), 64'(exp[63:32]));
			check(64'(wb_data[63]), 64'(exp[63]));
		end
		if (got_wb)
			check(64'(wb_dest), 64'(dest));
		if (got_exc)
			check(64'(exc_code), 64'(code));
		if (!ok)
			check(64'(got_req), 64'h0);
	endtask

	// ****************
	// Stimulus
	// ****************
	initial
	begin
		mclk = 1'b0;
		forever
			#12.5 mclk = ~mclk;
	end

	initial
	begin
		#125000;
		fail_count++;
		results();
	end

	initial
	begin
		resetn = 1'b0;
		issue_valid = 1'b0;
		instr_word = 32'h0;
		base_value = 64'h0;
		dest_old_value = 64'h0;
		cfg_bits = 3'h0;
		mem_delay = 2'h0;
		mem_err = 4'h0;
		fail_count = 0;
		checked = 0;
		for (int i = 0; i < 32; i++)
		begin
			rows[i].op = i[3] ? lft : rgt;
			rows[i].ofs = 16'hfff0 + {13'h0, i[4], i[1:0]};
			rows[i].cfg = {i[2], i[0] ^ i[4], i[3] ^ i[1]};
			// Same address as the run below: base 0x1_0000_0020 plus offset
			rows[i].exp = merge_exp(i[3],
				64'h1_0000_0010 + {61'h0, i[4], i[1:0]}, i[2]);
		end
		repeat (2) @(posedge mclk);
		resetn <= 1'b1;
		// Distinct destinations keep forwarding out of the table cases
		for (int i = 0; i < 32; i++)
			run(rows[i].op, 64'h1_0000_0020, rows[i].ofs, 5'(i), old,
				rows[i].cfg, 4'h0, rows[i].exp);
		$display("table done");
		@(posedge mclk);
		resetn <= 1'b0;
		@(posedge mclk);
		#1;
		check({59'h0, issue_ready, mem_req_valid, wb_valid, exc_valid, 1'b0},
			64'h10);
		@(posedge mclk);
		resetn <= 1'b1;
		$display("reset done");
		// Back to back on one destination, in both orders
		run(rgt, 64'h100, 16'h5, 5'h7, 64'h0, 3'h4, 4'h0, 64'h89ab);
		run(lft, 64'h100, 16'h2, 5'h7, 64'h0, 3'h4, 4'h0,
			64'hffff_ffff_8567_89ab);
		run(lft, 64'h100, 16'h2, 5'h8, 64'h0, 3'h4, 4'h0,
			64'hffff_ffff_8567_0000);
		run(rgt, 64'h100, 16'h5, 5'h8, 64'h0, 3'h4, 4'h0,
			64'hffff_ffff_8567_89ab);
		$display("pairs done");
		for (int e = 0; e < 5; e++)
			run(lft, 64'h100, 16'h2, 5'h8, 64'h0, 3'h4,
				e < 4 ? 4'(1 << e) : 4'hf, 64'h0);
		// A fault drops the forwarded value
		run(rgt, 64'h100, 16'h5, 5'h8, 64'h0, 3'h4, 4'h0, 64'h89ab);
		run(6'h23, 64'h100, 16'h2, 5'h8, 64'h0, 3'h4, 4'h0, 64'h0);
		$display("faults done");
		results();
	end
endmodule

`default_nettype wire
